// ---- hdl/ddr4_bank_burst_core.sv ----
`timescale 1ns/10ps
module ddr4_bank_burst_core
  import ddr4_burst_pkg::*;
(
  // Clocks and reset
  input  wire logic                              core_clk,
  input  wire logic                              srst,
  input  wire logic                              linkClk,
  // Command and address
  input  wire logic                              csN,
  input  wire logic                              actN,
  input  wire logic [16:0]                       addr,
  input  wire logic                              bankGroup,
  input  wire logic [1:0]                        bankAddr,
  input  wire logic                              parity,
  // Mode settings
  input  wire logic                              parityEnable,
  input  wire logic                              otfEnable,
  input  wire logic                              fixedChop,
  input  wire logic                              interleave,
  // Write CRC checker result
  input  wire logic                              crcError,
  // Data beats
  input  wire logic [ddr4_burst_pkg::DATA_W-1:0] wrBeatLo,
  input  wire logic [ddr4_burst_pkg::DATA_W-1:0] wrBeatHi,
  input  wire logic                              wrBeatValid,
  output logic      [ddr4_burst_pkg::DATA_W-1:0] rdBeatLo,
  output logic      [ddr4_burst_pkg::DATA_W-1:0] rdBeatHi,
  output logic                                   rdBeatValid,
  // Alert pin
  input  wire logic                              alertIn,
  output logic                                   alertOut,
  output logic                                   alertOe,
  // Connectivity test
  input  wire logic                              connectivity_test_enable,
  output logic                                   testMode,
  output logic                                   alertSample,
  // Status
  output logic                                   busy,
  output logic      [ddr4_burst_pkg::NUM_BANKS-1:0] bankOpen
);
  import ddr4_burst_pkg::*;

  typedef struct packed {
    core_st_t                            st;
    logic [MEM_DEPTH-1:0][WORD_W-1:0]    mem;
    logic [NUM_BANKS-1:0]                open;
    logic [NUM_BANKS-1:0][ROW_W-1:0]     row;
    logic [2:0]                          bank;
    logic [SLOT_W-1:0]                   slot;
    logic                                autoPre;
    logic [WORD_W-1:0]                   rdWord;
    logic                                chop;
    logic                                ilv;
    logic [2:0]                          startCol;
    logic                                rdReq;
    logic                                wrReq;
    logic [2:0]                          rdAckS;
    logic [2:0]                          wrAckS;
    logic [1:0]                          tenS;
    logic [1:0]                          alertS;
    logic                                testMode;
    logic                                alertLow;
    logic                                parHold;
    logic [CNT_W-1:0]                    alertCnt;
  } core_t;

  core_t      cs;
  core_t      next_cs;
  cmd_t       cmd;
  logic [2:0] idx;
  logic       parErr;
  logic       accept;
  logic       doAct;
  logic       doPre;
  logic       doRw;
  logic       ackEv;
  logic [ROW_W-1:0] rowIn;
  logic       a12;

  burst_xfer_if bus ();

  burst_beat_engine u_beats (
    .linkClk     (linkClk),
    .srst        (srst),
    .bus         (bus.link),
    .wrBeatLo    (wrBeatLo),
    .wrBeatHi    (wrBeatHi),
    .wrBeatValid (wrBeatValid),
    .rdBeatLo    (rdBeatLo),
    .rdBeatHi    (rdBeatHi),
    .rdBeatValid (rdBeatValid)
  );

  assign cmd = decodeCmd(csN, actN, addr[16:14]);
  assign idx = {bankGroup, bankAddr}; // RULE_06
  assign rowIn = addr[ROW_W-1:0];
  assign a12 = addr[12];
  // Even parity over command, address, group, bank and the parity pin
  assign parErr = parityEnable && !csN &&
                  ^{actN, addr, bankGroup, bankAddr, parity};
  // Commands during recovery, a burst or test mode are dropped
  assign accept = !cs.testMode && !parErr && !cs.parHold &&
                  cs.st == ST_IDLE;
  assign doAct = accept && cmd == CMD_ACT;
  assign doPre = accept && cmd == CMD_PRE;
  assign doRw = accept && (cmd == CMD_RD || cmd == CMD_WR) &&
                cs.open[idx];
  assign ackEv = cs.st == ST_READ ? cs.rdAckS[1] ^ cs.rdAckS[2]
                                  : cs.wrAckS[1] ^ cs.wrAckS[2];

  always_comb begin
    next_cs = cs;
    next_cs.rdAckS = {cs.rdAckS[1:0], bus.rdAck};
    next_cs.wrAckS = {cs.wrAckS[1:0], bus.wrAck};
    next_cs.tenS = {cs.tenS[0], connectivity_test_enable};
    next_cs.alertS = {cs.alertS[0], alertIn};
    next_cs.testMode = cs.tenS[1]; // RULE_04
    unique case (cs.st)
      ST_IDLE: begin
        if (doAct) begin // RULE_10
          next_cs.open[idx] = 1'b1;
          next_cs.row[idx] = rowIn;
        end
        if (doPre) begin // RULE_16
          if (addr[10]) begin
            next_cs.open = '0;
          end else begin
            next_cs.open[idx] = 1'b0;
          end
        end
        if (doRw) begin // RULE_11
          next_cs.bank = idx;
          next_cs.slot = addr[4:3];
          next_cs.startCol = addr[2:0];
          next_cs.autoPre = addr[10];
          next_cs.chop = otfEnable ? !a12 : fixedChop; // RULE_12 RULE_15
          next_cs.ilv = interleave;
          next_cs.rdWord = cs.mem[{idx, addr[4:3]}];
          if (cmd == CMD_RD) begin
            next_cs.rdReq = ~cs.rdReq;
            next_cs.st = ST_READ;
          end else begin
            next_cs.wrReq = ~cs.wrReq;
            next_cs.st = ST_WRITE;
          end
        end
      end
      ST_READ, ST_WRITE: begin
        if (ackEv) begin
          if (cs.st == ST_WRITE) begin
            next_cs.mem[{cs.bank, cs.slot}] = bus.wrWord; // RULE_07
          end
          if (cs.autoPre) begin // RULE_14
            next_cs.open[cs.bank] = 1'b0;
          end
          next_cs.st = ST_IDLE;
        end
      end
      default: next_cs.st = ST_IDLE;
    endcase
    // Parity recovery outranks and swallows a CRC pulse
    if (parErr) begin // RULE_02
      next_cs.alertLow = 1'b1;
      next_cs.parHold = 1'b1;
      next_cs.alertCnt = PAR_LOAD;
    end else if (crcError && !cs.parHold) begin // RULE_01
      next_cs.alertLow = 1'b1;
      next_cs.alertCnt = CRC_LOAD;
    end else if (cs.alertLow) begin
      if (cs.alertCnt == '0) begin
        next_cs.alertLow = 1'b0;
        next_cs.parHold = 1'b0;
      end else begin
        next_cs.alertCnt = CNT_W'(cs.alertCnt - 1'b1);
      end
    end
    if (srst) begin
      next_cs = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    cs <= next_cs;
  end

  assign bus.rdReq = cs.rdReq;
  assign bus.wrReq = cs.wrReq;
  assign bus.rdWord = cs.rdWord;
  assign bus.chop = cs.chop;
  assign bus.ilv = cs.ilv;
  assign bus.startCol = cs.startCol;

  assign alertOut = !cs.alertLow;
  assign alertOe = !cs.testMode; // RULE_03
  assign testMode = cs.testMode;
  assign alertSample = cs.alertS[1];
  assign busy = cs.st != ST_IDLE;
  assign bankOpen = cs.open;

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence crcPulse;
    !alertOut [*6];
  endsequence

  crc_alert_pulse_a: assert property ( // RULE_01
    (crcError && !parErr && !cs.parHold) |=> crcPulse)
    else $error("CRC alert pulse shorter than six cycles");
  crc_alert_end_a: assert property ( // RULE_01
    (cs.alertLow && !cs.parHold && cs.alertCnt == '0 && !crcError &&
     !parErr) |=> alertOut)
    else $error("CRC alert not released after its pulse");
  parity_alert_hold_a: assert property ( // RULE_02
    parErr |=> (!alertOut && cs.parHold) [*8])
    else $error("parity alert released too early");
  parity_release_a: assert property ( // RULE_02
    (cs.parHold && cs.alertCnt == '0 && !parErr) |=> alertOut)
    else $error("parity alert held after recovery");
  test_alert_input_a: assert property ( // RULE_03
    (cs.tenS[1] && $past(cs.tenS[1])) |->
      (!alertOe && alertSample == $past(alertIn, 2)))
    else $error("alert pin not an input in test mode");
  test_mode_entry_a: assert property ( // RULE_04
    $rose(cs.tenS[1]) |=> testMode ##0 !alertOe)
    else $error("test mode not entered on enable");
  act_opens_row_a: assert property ( // RULE_10
    doAct |=> cs.open[$past(idx)] && cs.row[$past(idx)] == $past(rowIn))
    else $error("activate did not open the addressed row");
  pre_all_banks_a: assert property ( // RULE_16
    (doPre && addr[10]) |=> cs.open == '0)
    else $error("precharge all left a bank open");
  pre_one_bank_a: assert property ( // RULE_16
    (doPre && !addr[10]) |=> !cs.open[$past(idx)])
    else $error("single precharge left the bank open");
  otf_chop_sel_a: assert property ( // RULE_15
    (doRw && otfEnable) |=> cs.chop == !$past(a12))
    else $error("on-the-fly chop selection wrong");
  auto_pre_close_a: assert property ( // RULE_14
    (cs.st != ST_IDLE && ackEv && cs.autoPre) |=> !cs.open[$past(cs.bank)])
    else $error("auto precharge did not close the bank");
endmodule // ddr4_bank_burst_core

// ---- hdl/ddr4_burst_pkg.sv ----
// Functional notes
// (RULE_01) Write CRC error drives alert low for a fixed pulse, then high.
// (RULE_02) Parity error holds alert low until internal recovery count ends.
// (RULE_03) In connectivity test mode the alert pin is an input only.
// (RULE_04) Test mode follows the test enable input, high enters, low leaves.
// (RULE_05) Controller keeps test enable low in normal operation.
// (RULE_06) Eight banks in two groups of four, each independently addressed.
// (RULE_07) One 8n word per burst, eight n-bit beats, two per link clock.
// (RULE_08) Bursts start at the column, eight beats or four when chopped.
// (RULE_09) Controller activates a row before reading or writing that bank.
// (RULE_10) Activate takes group, bank and row A0-A15 from the inputs.
// (RULE_11) Read or write takes start column from address, A10 for precharge.
// (RULE_12) With on-the-fly enabled, A12 selects chopped or full burst.
// (RULE_13) Controller initialises the device before normal commands.
// (RULE_14) A10 high on read or write closes the bank afterwards.
// (RULE_15) On-the-fly: A12 high gives eight beats, low gives four.
// (RULE_16) Precharge with A10 high closes all banks, else the addressed one.
package ddr4_burst_pkg;
  localparam int DATA_W = 16;
  localparam int WORD_W = 8 * DATA_W;
  localparam int NUM_BANKS = 8;
  localparam int ROW_W = 16;
  localparam int SLOT_W = 2;
  localparam int MEM_DEPTH = NUM_BANKS << SLOT_W;
  localparam int CRC_ALERT_CYCLES = 6;
  localparam int PAR_REC_CYCLES = 64;
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] CRC_LOAD = CNT_W'(CRC_ALERT_CYCLES - 1);
  localparam logic [CNT_W-1:0] PAR_LOAD = CNT_W'(PAR_REC_CYCLES - 1);
  localparam logic [1:0] LAST_PAIR_BL8 = 2'h3;
  localparam logic [1:0] LAST_PAIR_BC4 = 2'h1;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE
  } cmd_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_READ = 2'h1, ST_WRITE = 2'h2
  } core_st_t;
  typedef enum logic [1:0] {
    LK_IDLE = 2'h0, LK_READ = 2'h1, LK_WRITE = 2'h2
  } link_st_t;

  // Command pins: A16/A15/A14 double as row, column and write strobes
  function automatic cmd_t decodeCmd(input logic csN, input logic actN,
                                     input logic [2:0] rcw);
    decodeCmd = CMD_NOP;
    if (!csN && !actN) begin
      decodeCmd = CMD_ACT;
    end else if (!csN) begin
      unique case (rcw)
        3'h5:    decodeCmd = CMD_RD;
        3'h4:    decodeCmd = CMD_WR;
        3'h2:    decodeCmd = CMD_PRE;
        default: decodeCmd = CMD_NOP;
      endcase
    end
  endfunction

  // Beat order within the 8n word
  function automatic logic [2:0] beatSel(input logic [2:0] s,
                                         input logic [2:0] i,
                                         input logic ilv);
    beatSel = ilv ? (s ^ i) : {s[2] ^ i[2], 2'(s[1:0] + i[1:0])};
  endfunction
endpackage

// ---- hdl/burst_xfer_if.sv ----
`timescale 1ns/10ps
interface burst_xfer_if;
  import ddr4_burst_pkg::*;
  logic              rdReq;
  logic              wrReq;
  logic              rdAck;
  logic              wrAck;
  logic [WORD_W-1:0] rdWord;
  logic [WORD_W-1:0] wrWord;
  logic              chop;
  logic              ilv;
  logic [2:0]        startCol;
  modport core (output rdReq, wrReq, rdWord, chop, ilv, startCol,
                input rdAck, wrAck, wrWord);
  modport link (input rdReq, wrReq, rdWord, chop, ilv, startCol,
                output rdAck, wrAck, wrWord);
endinterface // burst_xfer_if

// ---- hdl/burst_beat_engine.sv ----
`timescale 1ns/10ps
module burst_beat_engine
  import ddr4_burst_pkg::*;
(
  // Link clock and core reset
  input  wire logic              linkClk,
  input  wire logic              srst,
  // Core side
  burst_xfer_if.link             bus,
  // Beats at the pins
  input  wire logic [DATA_W-1:0] wrBeatLo,
  input  wire logic [DATA_W-1:0] wrBeatHi,
  input  wire logic              wrBeatValid,
  output logic      [DATA_W-1:0] rdBeatLo,
  output logic      [DATA_W-1:0] rdBeatHi,
  output logic                   rdBeatValid
);
  typedef struct packed {
    logic [1:0]        rst;
    logic [2:0]        rdReqS;
    logic [2:0]        wrReqS;
    link_st_t          st;
    logic [1:0]        pair;
    logic [WORD_W-1:0] word;
    logic [DATA_W-1:0] lo;
    logic [DATA_W-1:0] hi;
    logic              valid;
    logic              rdAck;
    logic              wrAck;
  } link_t;

  link_t lk;
  link_t next_lk;
  logic  rdEv;
  logic  wrEv;
  logic  lastPair;
  logic  [2:0] iLo;
  logic  [2:0] iHi;

  assign rdEv = lk.rdReqS[1] ^ lk.rdReqS[2];
  assign wrEv = lk.wrReqS[1] ^ lk.wrReqS[2];
  assign lastPair = lk.pair == (bus.chop ? LAST_PAIR_BC4 : LAST_PAIR_BL8);
  assign iLo = beatSel(bus.startCol, {lk.pair, 1'b0}, bus.ilv); // RULE_08
  assign iHi = beatSel(bus.startCol, {lk.pair, 1'b1}, bus.ilv); // RULE_08

  always_comb begin
    next_lk = lk;
    next_lk.valid = 1'b0;
    if (lk.rst[1]) begin
      next_lk = '0;
    end else begin
      unique case (lk.st)
        LK_IDLE: begin
          next_lk.pair = '0;
          if (rdEv) begin
            next_lk.st = LK_READ;
          end else if (wrEv) begin
            // Chopped writes keep the untouched beats of the old word
            next_lk.word = bus.rdWord;
            next_lk.st = LK_WRITE;
          end
        end
        LK_READ: begin
          // Two beats per link clock, rising then falling half
          next_lk.valid = 1'b1; // RULE_07
          next_lk.lo = bus.rdWord[int'(iLo)*DATA_W +: DATA_W];
          next_lk.hi = bus.rdWord[int'(iHi)*DATA_W +: DATA_W];
          next_lk.pair = 2'(lk.pair + 2'h1);
          if (lastPair) begin // RULE_08
            next_lk.st = LK_IDLE;
            next_lk.rdAck = ~lk.rdAck;
          end
        end
        LK_WRITE: begin
          if (wrBeatValid) begin // RULE_07
            next_lk.word[int'(iLo)*DATA_W +: DATA_W] = wrBeatLo;
            next_lk.word[int'(iHi)*DATA_W +: DATA_W] = wrBeatHi;
            next_lk.pair = 2'(lk.pair + 2'h1);
            if (lastPair) begin // RULE_08
              next_lk.st = LK_IDLE;
              next_lk.wrAck = ~lk.wrAck;
            end
          end
        end
        default: next_lk.st = LK_IDLE;
      endcase
    end
    next_lk.rst = {lk.rst[0], srst};
    next_lk.rdReqS = {lk.rdReqS[1:0], bus.rdReq};
    next_lk.wrReqS = {lk.wrReqS[1:0], bus.wrReq};
  end

  always_ff @(posedge linkClk) begin
    lk <= next_lk;
  end

  assign rdBeatLo = lk.lo;
  assign rdBeatHi = lk.hi;
  assign rdBeatValid = lk.valid;
  assign bus.rdAck = lk.rdAck;
  assign bus.wrAck = lk.wrAck;
  assign bus.wrWord = lk.word;

  sequence fullBurs;
    rdBeatValid [*4] ##1 !rdBeatValid;
  endsequence
  sequence chopBurst;
    rdBeatValid [*2] ##1 !rdBeatValid;
  endsequence

  read_bl8_beats_a: assert property (@(posedge linkClk) // RULE_08
    disable iff (lk.rst[1])
    (lk.st == LK_IDLE && rdEv && !bus.chop) |-> ##2 fullBurs)
    else $error("full burst is not four link clocks of beats");
  read_bc4_beats_a: assert property (@(posedge linkClk) // RULE_08
    disable iff (lk.rst[1])
    (lk.st == LK_IDLE && rdEv && bus.chop) |-> ##2 chopBurst)
    else $error("chopped burst is not two link clocks of beats");
endmodule // burst_beat_engine

// ---- verification/ctrl_link_model.sv ----
`timescale 1ns/10ps
module ctrl_link_model
  import ddr4_burst_pkg::*;
(
  // Link side of the controller
  input  wire logic              linkClk,
  input  wire logic [DATA_W-1:0] rdBeatLo,
  input  wire logic [DATA_W-1:0] rdBeatHi,
  input  wire logic              rdBeatValid,
  output logic      [DATA_W-1:0] wrBeatLo,
  output logic      [DATA_W-1:0] wrBeatHi,
  output logic                   wrBeatValid
);
  logic [DATA_W-1:0] rdQ[$];

  initial begin
    wrBeatLo    = 16'h0000;
    wrBeatHi    = 16'hffff;
    wrBeatValid = 1'b0;
  end

  // Pairs go out even beat low, odd beat high
  task automatic sendPairs(input logic [DATA_W-1:0] b[8], input int n);
    // Wait out link arming, earlier beats would be lost
    repeat (8) @(negedge linkClk);
    for (int k = 0; k < n; k++) begin
      wrBeatLo    = b[2*k];
      wrBeatHi    = b[2*k+1];
      wrBeatValid = 1'b1;
      @(negedge linkClk);
    end
    // Released lines invert so stale data never passes for good data
    wrBeatValid = 1'b0;
    wrBeatLo    = ~wrBeatLo;
    wrBeatHi    = ~wrBeatHi;
  endtask

  always @(posedge linkClk) begin
    if (rdBeatValid === 1'b1) begin
      rdQ.push_back(rdBeatLo);
      rdQ.push_back(rdBeatHi);
    end
  end
endmodule // ctrl_link_model

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  import ddr4_burst_pkg::*;
  logic              core_clk, srst, linkClk, csN, actN, bankGroup, parity;
  logic [16:0]       addr;
  logic [1:0]        bankAddr;
  logic              parityEnable, otfEnable, fixedChop, interleave;
  logic              crcError, wrBeatValid, rdBeatValid, busy;
  logic [DATA_W-1:0] wrBeatLo, wrBeatHi, rdBeatLo, rdBeatHi;
  logic              alertIn, alertOut, alertOe, alertDrv, testMode;
  logic              connectivity_test_enable, alertSample;
  logic [7:0]        bankOpen;
  logic [DATA_W-1:0] refMem[32][8];
  int                errorCnt, checked;

  // Testbench drives the alert line from alertDrv whenever the core releases it
  assign alertIn = alertOe ? alertOut : alertDrv;

  ddr4_bank_burst_core DUT (.core_clk, .srst, .linkClk, .csN, .actN, .addr,
    .bankGroup, .bankAddr, .parity, .parityEnable, .otfEnable, .fixedChop,
    .interleave, .crcError, .wrBeatLo, .wrBeatHi, .wrBeatValid, .rdBeatLo,
    .rdBeatHi, .rdBeatValid, .alertIn, .alertOut, .alertOe,
    .connectivity_test_enable, .testMode, .alertSample, .busy, .bankOpen);

  ctrl_link_model PART (.linkClk, .rdBeatLo, .rdBeatHi, .rdBeatValid,
    .wrBeatLo, .wrBeatHi, .wrBeatValid);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    linkClk = 1'b0;
    #1.3;
    forever #3 linkClk = ~linkClk;
  end

  task automatic chk(input logic c, input string msg);
    checked++;
    if (c !== 1'b1) begin
      errorCnt++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  function automatic int pos(input int s, input int i, input logic ilv);
    return ilv ? (s ^ i) : (((s ^ i) & 4) | ((s + i) & 3));
  endfunction

  function automatic logic [16:0] mkAddr(input logic [2:0] rcw,
      input logic a12, input logic a10, input int sl, input int s);
    return {rcw, 1'b0, a12, 1'b0, a10, 5'h00, 2'(sl), 3'(s)};
  endfunction

  task automatic drive(input logic act, input logic [16:0] a,
                       input logic [2:0] bk, input logic bad);
    @(negedge core_clk);
    csN = 1'b0;
    actN = act;
    addr = a;
    {bankGroup, bankAddr} = bk;
    parity = ^{act, a, bk} ^ bad;
  endtask

  task automatic cmd(input logic act, input logic [16:0] a,
                     input logic [2:0] bk);
    drive(act, a, bk, 1'b0);
    @(negedge core_clk);
    csN = 1'b1;
  endtask

  task automatic waitIdle();
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge core_clk);
    chk(busy === 1'b0, "busy stuck");
  endtask

  task automatic wrXfer(input logic [2:0] bk, input int sl, input int s,
                        input logic a12, input logic [15:0] base);
    logic [DATA_W-1:0] b[8];
    int n;
    n = a12 ? 4 : 2;
    for (int i = 0; i < 8; i++) b[i] = base + 16'(i);
    for (int i = 0; i < 2*n; i++)
      refMem[{bk, 2'(sl)}][pos(s, i, interleave)] = b[i];
    cmd(1'b1, mkAddr(3'h4, a12, 1'b0, sl, s), bk);
    PART.sendPairs(b, n);
    waitIdle();
  endtask

  task automatic rdXfer(input logic [2:0] bk, input int sl, input int s,
                        input logic a12, input logic a10, input int n);
    logic [DATA_W-1:0] want;
    PART.rdQ.delete();
    cmd(1'b1, mkAddr(3'h5, a12, a10, sl, s), bk);
    waitIdle();
    chk(PART.rdQ.size() == 2*n, "read beat count");
    for (int i = 0; i < 2*n && i < PART.rdQ.size(); i++) begin
      want = refMem[{bk, 2'(sl)}][pos(s, i, interleave)];
      chk(PART.rdQ[i] === want, "read beat");
    end
  endtask

  task automatic countLow(input int exp, input string msg);
    int lows;
    lows = 0;
    repeat (exp + 20) begin
      @(negedge core_clk);
      crcError = 1'b0;
      csN = 1'b1;
      if (alertOut === 1'b0) lows++;
    end
    chk(lows == exp, msg);
  endtask

  task automatic banksTest();
    for (int k = 0; k < 8; k++) cmd(1'b0, 17'h0abcd, 3'(k));
    @(negedge core_clk);
    chk(bankOpen === 8'hff, "all banks open");
    cmd(1'b1, mkAddr(3'h2, 1'b0, 1'b0, 0, 0), 3'h3);
    @(negedge core_clk);
    chk(bankOpen === 8'hf7, "single precharge");
    cmd(1'b1, mkAddr(3'h2, 1'b0, 1'b1, 0, 0), 3'h0);
    @(negedge core_clk);
    chk(bankOpen === 8'h00, "precharge all");
    cmd(1'b1, mkAddr(3'h5, 1'b1, 1'b0, 0, 0), 3'h1);
    repeat (3) @(negedge core_clk);
    chk(busy === 1'b0, "read of closed bank ran");
  endtask

  task automatic burstTest();
    cmd(1'b0, 17'h01234, 3'h2);
    wrXfer(3'h2, 1, 0, 1'b1, 16'h1110);
    chk(bankOpen[2] === 1'b1, "row left open");
    interleave = 1'b1;
    rdXfer(3'h2, 1, 5, 1'b1, 1'b1, 4);
    chk(bankOpen[2] === 1'b0, "no auto precharge");
    interleave = 1'b0;
    cmd(1'b0, 17'h01234, 3'h2);
    wrXfer(3'h2, 1, 4, 1'b0, 16'h2220);
    rdXfer(3'h2, 1, 1, 1'b0, 1'b0, 2);
    otfEnable = 1'b0;
    rdXfer(3'h2, 1, 0, 1'b0, 1'b0, 4);
    fixedChop = 1'b1;
    rdXfer(3'h2, 1, 6, 1'b1, 1'b0, 2);
    fixedChop = 1'b0;
    otfEnable = 1'b1;
  endtask

  task automatic alertTest();
    @(negedge core_clk);
    crcError = 1'b1;
    countLow(CRC_ALERT_CYCLES, "crc alert length");
    drive(1'b0, 17'h00000, 3'h7, 1'b1);
    countLow(PAR_REC_CYCLES, "parity alert length");
    chk(bankOpen[7] === 1'b0, "errored command taken");
    // Check off: the same errored command opens the bank, no alert
    parityEnable = 1'b0;
    drive(1'b0, 17'h00000, 3'h7, 1'b1);
    countLow(0, "alert with parity check off");
    chk(bankOpen[7] === 1'b1, "unchecked command dropped");
    parityEnable = 1'b1;
  endtask

  task automatic resetTest();
    cmd(1'b0, 17'h00000, 3'h5);
    crcError = 1'b1;
    @(negedge core_clk);
    crcError = 1'b0;
    chk(alertOut === 1'b0, "crc alert before reset");
    chk(bankOpen[5] === 1'b1, "bank before reset");
    srst = 1'b1;
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    chk(alertOut === 1'b1 && busy === 1'b0, "alert after mid-run reset");
    chk(bankOpen === 8'h00, "banks after mid-run reset");
    // Link domain leaves reset two link clocks later
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 32; i++) refMem[i] = '{default: 16'h0000};
    cmd(1'b0, 17'h01234, 3'h2);
    rdXfer(3'h2, 1, 0, 1'b1, 1'b0, 4);
  endtask

  task automatic testModeTest();
    connectivity_test_enable = 1'b1;
    repeat (6) @(negedge core_clk);
    chk(testMode === 1'b1 && alertOe === 1'b0, "test entry");
    alertDrv = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(alertSample === 1'b0, "alert input low");
    alertDrv = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(alertSample === 1'b1, "alert input high");
    connectivity_test_enable = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(testMode === 1'b0 && alertOe === 1'b1, "test exit");
  endtask

  task automatic giveVerdict();
    if (errorCnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    {csN, actN, bankGroup, parity, addr, bankAddr} = {2'h3, 21'h000000};
    {otfEnable, fixedChop, interleave, crcError} = 4'h8;
    parityEnable = 1'b1;
    alertDrv = 1'b1;
    connectivity_test_enable = 1'b0;
    errorCnt = 0;
    checked = 0;
    for (int i = 0; i < 32; i++) refMem[i] = '{default: 16'h0000};
    srst = 1'b1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    chk(alertOut === 1'b1 && alertOe === 1'b1, "alert after reset");
    chk(testMode === 1'b0 && bankOpen === 8'h00, "state after reset");
    banksTest();
    burstTest();
    alertTest();
    resetTest();
    testModeTest();
    giveVerdict();
  end

  // Whole run is under a thousand core cycles, so this only cuts a hang
  initial begin
    #100000;
    errorCnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    giveVerdict();
  end
endmodule // tb_top
